// *** ies_seq.sv ***
// Interrupt return, chaining and system exception sequencer with Wishbone registers
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
module ies_seq (
    input  wire logic                         clk_sys, // System clock
    input  wire logic                         rst,     // Async reset, active high
    input  wire ies_pkg::ies_wb_in_t          wb_i,    // Wishbone request
    output ies_pkg::ies_wb_out_t              wb_o,    // Wishbone answer
    input  wire ies_pkg::ies_cmd_t            cmd,     // CPU commands
    output ies_pkg::ies_res_t                 res,     // Sequence result
    output ies_pkg::ies_mem_t                 mem_o,   // Byte memory request
    input  wire logic                         mem_ack, // Memory done pulse
    input  wire logic [7:0]                   mem_rd,  // Memory read byte
    input  wire logic [ies_pkg::NUM_IRQ-1:0]  irq_hw,  // Controller requests
    output logic [7:0]                        flags_o, // Flags register
    output logic [ies_pkg::NUM_IRQ-1:0]       req_o    // Request register
);

    typedef struct packed {
        ies_pkg::ies_state_t state;
        logic [2:0]          cnt;
        logic                is_exc;
        logic [31:0]         sp_w;
        logic [31:0]         pc_w;
        logic [31:0]         vec_a;
        logic [7:0]          flags;
        logic [7:0]          req;
        logic [7:0]          en;
        logic [31:0]         pc_lim;
        logic                pcf;
        logic                exc_pend;
        logic                wb_ack;
        logic [31:0]         wb_dat;
        ies_pkg::ies_mem_t   mem;
        logic                done;
        logic                busy;
        logic [31:0]         out_pc;
        logic [31:0]         out_sp;
    } ies_st_t;

    ies_st_t r_reg;
    ies_st_t r_next;

    logic       pick_any;
    logic [2:0] pick_idx;
    logic [7:0] pick_hot;
    logic       wb_hit;
    logic       wb_wr;
    logic       fault_ev;
    logic [7:0] push_byte;
    logic [31:0] pick_vec;

    ies_pick u_pick (
        .pend   (r_reg.req & r_reg.en),
        .any    (pick_any),
        .idx    (pick_idx),
        .onehot (pick_hot)
    );

    assign wb_hit   = wb_i.cyc & wb_i.stb & ~r_reg.wb_ack;
    assign wb_wr    = wb_hit & wb_i.we;
    assign pick_vec = ies_pkg::IRQ_VEC_BASE + {27'h0, pick_idx, 2'b00};
    assign fault_ev = cmd.fetch & (cmd.fetch_pc > r_reg.pc_lim) & ~r_reg.pcf;

    always_comb begin
        case (r_reg.cnt)
            3'h0:    push_byte = r_reg.flags;
            3'h1:    push_byte = ies_pkg::PAD_BYTE;
            3'h2:    push_byte = r_reg.pc_w[7:0];
            3'h3:    push_byte = r_reg.pc_w[15:8];
            3'h4:    push_byte = r_reg.pc_w[23:16];
            default: push_byte = r_reg.pc_w[31:24];
        endcase
    end

    always_comb begin
        logic [7:0] set_req;
        logic [7:0] clr_req;
        logic       clr_pcf;
        set_req = irq_hw;
        clr_req = 8'h00;
        clr_pcf = 1'b0;
        r_next  = r_reg;
        r_next.wb_ack = 1'b0;
        r_next.done   = 1'b0;

        // Register slave, software effects first, sequencer overrides below
        if (wb_hit) begin
            r_next.wb_ack = 1'b1;
            r_next.wb_dat = 32'h0000_0000;
            case ({wb_i.adr[7:2], 2'b00})
                ies_pkg::OFS_FLAGS: begin
                    r_next.wb_dat = {24'h000000, r_reg.flags};
                    if (wb_wr && wb_i.sel[0]) begin
                        r_next.flags = wb_i.dat[7:0];
                    end
                end
                ies_pkg::OFS_REQ: begin
                    r_next.wb_dat = {24'h000000, r_reg.req};
                    if (wb_wr && wb_i.sel[0]) begin
                        clr_req = wb_i.dat[7:0];
                    end
                end
                ies_pkg::OFS_REQ_SET: begin
                    r_next.wb_dat = {24'h000000, r_reg.req};
                    if (wb_wr && wb_i.sel[0]) begin
                        set_req = irq_hw | wb_i.dat[7:0];
                    end
                end
                ies_pkg::OFS_ENABLE: begin
                    r_next.wb_dat = {24'h000000, r_reg.en};
                    if (wb_wr && wb_i.sel[0]) begin
                        r_next.en = wb_i.dat[7:0];
                    end
                end
                ies_pkg::OFS_PC_LIMIT: begin
                    r_next.wb_dat = r_reg.pc_lim;
                    for (int b = 0; b < 4; b++) begin
                        if (wb_wr && wb_i.sel[b]) begin
                            r_next.pc_lim[8*b +: 8] = wb_i.dat[8*b +: 8];
                        end
                    end
                end
                ies_pkg::OFS_SYS_EXC: begin
                    r_next.wb_dat = {31'h0, r_reg.pcf};
                    if (wb_wr && wb_i.sel[0]) begin
                        clr_pcf = wb_i.dat[ies_pkg::SYS_PCF];
                    end
                end
                default: r_next.wb_dat = 32'h0000_0000;
            endcase
        end

        case (r_reg.state)
            ies_pkg::ST_IDLE: begin
                if (cmd.boundary && r_reg.exc_pend) begin
                    // Not gated by any enable
                    r_next.state    = ies_pkg::ST_PUSH;
                    r_next.is_exc   = 1'b1;
                    r_next.exc_pend = 1'b0;
                    r_next.cnt      = 3'h0;
                    r_next.sp_w     = cmd.sp;
                    r_next.pc_w     = cmd.ret_pc;
                    r_next.vec_a    = ies_pkg::EXC_VECTOR;
                end else if (cmd.boundary && cmd.return_from_interrupt) begin
                    r_next.cnt  = 3'h0;
                    r_next.sp_w = cmd.sp;
                    if (r_reg.flags[ies_pkg::FLAG_CHAIN] && pick_any) begin
                        r_next.state = ies_pkg::ST_VEC;
                        r_next.is_exc = 1'b0;
                        r_next.vec_a = pick_vec;
                        r_next.flags[ies_pkg::FLAG_MIE] = 1'b0;
                        clr_req = clr_req | pick_hot;
                    end else begin
                        r_next.state = ies_pkg::ST_POP;
                    end
                end else if (cmd.boundary && r_reg.flags[ies_pkg::FLAG_MIE] && pick_any) begin
                    r_next.state  = ies_pkg::ST_PUSH;
                    r_next.is_exc = 1'b0;
                    r_next.cnt    = 3'h0;
                    r_next.sp_w   = cmd.sp;
                    r_next.pc_w   = cmd.ret_pc;
                    r_next.vec_a  = pick_vec;
                    clr_req = clr_req | pick_hot;
                end else if (cmd.boundary && cmd.ei) begin
                    r_next.flags[ies_pkg::FLAG_MIE] = 1'b1;
                end else if (cmd.boundary && cmd.di) begin
                    r_next.flags[ies_pkg::FLAG_MIE] = 1'b0;
                end
            end
            ies_pkg::ST_PUSH: begin
                if (r_reg.cnt == ies_pkg::PAD_STEP && r_reg.is_exc) begin
                    // Pad slot left untouched, pointer still moves
                    r_next.sp_w = r_reg.sp_w - ies_pkg::SP_ONE;
                    r_next.cnt  = r_reg.cnt + 3'h1;
                end else if (!r_reg.mem.req) begin
                    r_next.mem.req   = 1'b1;
                    r_next.mem.we    = 1'b1;
                    r_next.mem.addr  = r_reg.sp_w - ies_pkg::SP_ONE;
                    r_next.mem.wdata = push_byte;
                end else if (mem_ack) begin
                    r_next.mem.req = 1'b0;
                    r_next.mem.we  = 1'b0;
                    r_next.sp_w    = r_reg.sp_w - ies_pkg::SP_ONE;
                    r_next.cnt     = r_reg.cnt + 3'h1;
                    if (r_reg.cnt == 3'h0) begin
                        r_next.flags[ies_pkg::FLAG_CHAIN] = r_reg.flags[ies_pkg::FLAG_MIE];
                    end
                    if (r_reg.cnt == ies_pkg::PUSH_LAST) begin
                        r_next.state = ies_pkg::ST_VEC;
                        r_next.cnt   = 3'h0;
                        if (!r_reg.is_exc) begin
                            r_next.flags[ies_pkg::FLAG_MIE] = 1'b0;
                        end
                    end
                end
            end
            ies_pkg::ST_VEC: begin
                if (!r_reg.mem.req) begin
                    r_next.mem.req  = 1'b1;
                    r_next.mem.we   = 1'b0;
                    r_next.mem.addr = r_reg.vec_a + {29'h0, r_reg.cnt};
                end else if (mem_ack) begin
                    r_next.mem.req = 1'b0;
                    r_next.pc_w    = {r_reg.pc_w[23:0], mem_rd};
                    r_next.cnt     = r_reg.cnt + 3'h1;
                    if (r_reg.cnt == ies_pkg::QUAD_LAST) begin
                        r_next.state = ies_pkg::ST_DONE;
                    end
                end
            end
            ies_pkg::ST_POP: begin
                if (!r_reg.mem.req) begin
                    r_next.mem.req  = 1'b1;
                    r_next.mem.we   = 1'b0;
                    r_next.mem.addr = r_reg.sp_w;
                end else if (mem_ack) begin
                    r_next.mem.req = 1'b0;
                    r_next.pc_w    = {r_reg.pc_w[23:0], mem_rd};
                    r_next.sp_w    = r_reg.sp_w + ies_pkg::SP_ONE;
                    r_next.cnt     = r_reg.cnt + 3'h1;
                    if (r_reg.cnt == ies_pkg::QUAD_LAST) begin
                        r_next.sp_w  = r_reg.sp_w + ies_pkg::SP_POP_PAD;
                        r_next.state = ies_pkg::ST_FLAGS;
                    end
                end
            end
            ies_pkg::ST_FLAGS: begin
                if (!r_reg.mem.req) begin
                    r_next.mem.req  = 1'b1;
                    r_next.mem.we   = 1'b0;
                    r_next.mem.addr = r_reg.sp_w;
                end else if (mem_ack) begin
                    r_next.mem.req = 1'b0;
                    r_next.flags   = mem_rd;
                    r_next.sp_w    = r_reg.sp_w + ies_pkg::SP_ONE;
                    r_next.state   = ies_pkg::ST_DONE;
                end
            end
            ies_pkg::ST_DONE: begin
                r_next.done   = 1'b1;
                r_next.out_pc = r_reg.pc_w;
                r_next.out_sp = r_reg.sp_w;
                r_next.state  = ies_pkg::ST_IDLE;
            end
            default: r_next.state = ies_pkg::ST_IDLE;
        endcase

        // Hardware sets win over software clears
        r_next.req      = (r_reg.req & ~clr_req) | set_req;
        r_next.pcf      = (r_reg.pcf & ~clr_pcf) | fault_ev;
        r_next.exc_pend = r_next.exc_pend | fault_ev | cmd.exc_raise;
        r_next.busy     = (r_next.state != ies_pkg::ST_IDLE);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r_reg        <= '0;
            r_reg.state  <= ies_pkg::ST_IDLE;
            r_reg.flags  <= ies_pkg::RST_FLAGS;
            r_reg.req    <= ies_pkg::RST_REQ;
            r_reg.en     <= ies_pkg::RST_ENABLE;
            r_reg.pc_lim <= ies_pkg::RST_PC_LIMIT;
        end else begin
            r_reg <= r_next;
        end
    end

    assign wb_o    = '{ack: r_reg.wb_ack, dat: r_reg.wb_dat};
    assign mem_o   = r_reg.mem;
    assign res     = '{done: r_reg.done, busy: r_reg.busy, pc: r_reg.out_pc, sp: r_reg.out_sp};
    assign flags_o = r_reg.flags;
    assign req_o   = r_reg.req;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic push_ack;
    logic return_from_interrupt_chain;
    assign push_ack   = (r_reg.state == ies_pkg::ST_PUSH) && r_reg.mem.req && mem_ack;
    assign return_from_interrupt_chain = (r_reg.state == ies_pkg::ST_IDLE) && cmd.boundary && !r_reg.exc_pend
                        && cmd.return_from_interrupt && r_reg.flags[ies_pkg::FLAG_CHAIN] && pick_any;

    sequence s_flags_pushed;
        push_ack && (r_reg.cnt == 3'h0);
    endsequence

    sequence s_last_pop;
        (r_reg.state == ies_pkg::ST_POP) && r_reg.mem.req && mem_ack
            && (r_reg.cnt == ies_pkg::QUAD_LAST);
    endsequence

    chain_copy_a: assert property (s_flags_pushed |=>
        r_reg.flags[ies_pkg::FLAG_CHAIN] == $past(r_reg.flags[ies_pkg::FLAG_MIE]))
        else $error("chain flag not copied from master enable");

    pad_skip_a: assert property (s_last_pop |=>
        (r_reg.state == ies_pkg::ST_FLAGS) && (r_reg.sp_w == $past(r_reg.sp_w) + 32'h2))
        else $error("pad byte not skipped after last pop");

    chain_go_a: assert property (return_from_interrupt_chain |=> (r_reg.state == ies_pkg::ST_VEC)
        && !r_reg.flags[ies_pkg::FLAG_MIE] && (r_reg.sp_w == $past(cmd.sp)))
        else $error("chained return did not go to vector fetch");

    chain_nowrite_a: assert property (return_from_interrupt_chain |=>
        !(r_reg.mem.req && r_reg.mem.we) [*8])
        else $error("chained return touched the stack");

    push_write_a: assert property ((r_reg.state == ies_pkg::ST_PUSH) && r_reg.mem.req
        |-> r_reg.mem.we && (r_reg.mem.addr == r_reg.sp_w - 32'h1))
        else $error("push request malformed");

    exc_vector_a: assert property ($rose(r_reg.state == ies_pkg::ST_VEC) && r_reg.is_exc
        |-> r_reg.vec_a == ies_pkg::EXC_VECTOR)
        else $error("exception vector quad wrong");

    pcf_sticky_a: assert property (r_reg.pcf && !(wb_wr && wb_i.sel[0]
        && ({wb_i.adr[7:2], 2'b00} == ies_pkg::OFS_SYS_EXC) && wb_i.dat[0]) |=> r_reg.pcf)
        else $error("pc limit flag lost");

    pcf_set_a: assert property (cmd.fetch && (cmd.fetch_pc > r_reg.pc_lim) && !r_reg.pcf
        |=> r_reg.pcf && r_reg.exc_pend)
        else $error("pc limit fault not raised");

    req_set_a: assert property (wb_wr && wb_i.sel[0] && (wb_i.dat[7:0] != 8'h00)
        && ({wb_i.adr[7:2], 2'b00} == ies_pkg::OFS_REQ_SET)
        |=> (r_reg.req & $past(wb_i.dat[7:0])) == $past(wb_i.dat[7:0]))
        else $error("software request not raised");

    wb_ack_a: assert property (r_reg.wb_ack |=> !r_reg.wb_ack)
        else $error("ack held longer than one cycle");

endmodule : ies_seq

// *** ies_pkg.sv ***
// Constants, states and carrier structs of the interrupt return and exception sequencer
package ies_pkg;

    localparam int NUM_IRQ = 8;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] OFS_FLAGS    = 8'h00;
    localparam logic [7:0] OFS_REQ      = 8'h04;
    localparam logic [7:0] OFS_REQ_SET  = 8'h08;
    localparam logic [7:0] OFS_ENABLE   = 8'h0C;
    localparam logic [7:0] OFS_PC_LIMIT = 8'h10;
    localparam logic [7:0] OFS_SYS_EXC  = 8'h14;

    // Field positions
    localparam int FLAG_MIE   = 0;
    localparam int FLAG_CHAIN = 1;
    localparam int SYS_PCF    = 0;

    // Reset values
    localparam logic [7:0]  RST_FLAGS    = 8'h00;
    localparam logic [7:0]  RST_REQ      = 8'h00;
    localparam logic [7:0]  RST_ENABLE   = 8'h00;
    localparam logic [31:0] RST_PC_LIMIT = 32'hFFFF_FFFF;

    // Vector quads and stack layout
    localparam logic [31:0] EXC_VECTOR   = 32'h0000_0008;
    localparam logic [31:0] IRQ_VEC_BASE = 32'h0000_0010;
    localparam logic [7:0]  PAD_BYTE     = 8'h00;
    localparam logic [2:0]  PAD_STEP     = 3'h1;
    localparam logic [2:0]  PUSH_LAST    = 3'h5;
    localparam logic [2:0]  QUAD_LAST    = 3'h3;
    localparam logic [31:0] SP_ONE       = 32'h0000_0001;
    localparam logic [31:0] SP_POP_PAD   = 32'h0000_0002;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_PUSH  = 6'b000010,
        ST_VEC   = 6'b000100,
        ST_POP   = 6'b001000,
        ST_FLAGS = 6'b010000,
        ST_DONE  = 6'b100000
    } ies_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } ies_wb_in_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } ies_wb_out_t;

    typedef struct packed {
        logic        boundary;
        logic        return_from_interrupt;
        logic        ei;
        logic        di;
        logic        fetch;
        logic        exc_raise;
        logic [31:0] fetch_pc;
        logic [31:0] ret_pc;
        logic [31:0] sp;
    } ies_cmd_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } ies_mem_t;

    typedef struct packed {
        logic        done;
        logic        busy;
        logic [31:0] pc;
        logic [31:0] sp;
    } ies_res_t;

endpackage : ies_pkg

// *** ies_pick.sv ***
// Fixed-priority picker: lowest index wins
module ies_pick (
    input  wire logic [ies_pkg::NUM_IRQ-1:0] pend,   // Enabled pending requests
    output logic                             any,    // At least one pending
    output logic [2:0]                       idx,    // Winning index
    output logic [ies_pkg::NUM_IRQ-1:0]      onehot  // Winning bit
);

    logic [ies_pkg::NUM_IRQ:0] seen;

    assign seen[0] = 1'b0;

    genvar i;
    generate
        for (i = 0; i < ies_pkg::NUM_IRQ; i++) begin : g_bit
            assign seen[i+1]  = seen[i] | pend[i];
            assign onehot[i]  = pend[i] & ~seen[i];
        end
    endgenerate

    assign any = seen[ies_pkg::NUM_IRQ];

    always_comb begin
        idx = 3'h0;
        for (int k = 0; k < ies_pkg::NUM_IRQ; k++) begin
            if (onehot[k]) begin
                idx = 3'(k);
            end
        end
    end

endmodule : ies_pick

// *** ies_mem_model.sv ***
// Byte memory partner answering stack and vector requests
module ies_mem_model (
    input  wire logic              clk_sys, // System clock
    input  wire ies_pkg::ies_mem_t mem_o,   // Byte request
    output logic                   mem_ack, // Done pulse
    output logic [7:0]             mem_rd   // Read byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [logic [31:0]];
    int         seed = 34;
    int         wait_n = 0;
    initial begin
        mem_ack = 1'b0;
        mem_rd  = 8'h00;
    end
    always @(posedge clk_sys) begin
        mem_ack <= 1'b0;
        mem_rd  <= ~mem_rd; // Not valid outside ack
        if (mem_o.req && !mem_ack) begin
            if (wait_n == 0) begin
                mem_ack <= 1'b1;
                wait_n  <= $random(seed) & 1;
                if (mem_o.we) begin
                    mem[mem_o.addr] = mem_o.wdata;
                end else begin
                    mem_rd <= mem.exists(mem_o.addr) ? mem[mem_o.addr] : 8'h5A;
                end
            end else begin
                wait_n <= wait_n - 1;
            end
        end
    end
endmodule : ies_mem_model

// *** tb_ies_seq.sv ***
// Self-checking bench of the interrupt return and exception sequencer
module tb_ies_seq;
    timeunit 1ns;
    timeprecision 1ns;
    logic                clk_sys;
    logic                rst;
    ies_pkg::ies_wb_in_t wb_i;
    ies_pkg::ies_wb_out_t wb_o;
    ies_pkg::ies_cmd_t   cmd;
    ies_pkg::ies_res_t   res;
    ies_pkg::ies_mem_t   mem_o;
    logic                mem_ack;
    logic [7:0]          mem_rd;
    logic [7:0]          irq_hw;
    logic [7:0]          flags_o;
    logic [7:0]          req_o;
    int                  err_count = 0;
    int                  checks = 0;
    int                  seed = 34;
    logic [31:0]         rq[$];
    logic [63:0]         dq[$];
    logic [31:0]         s_ptr;
    logic [31:0]         r_pc;
    logic [31:0]         v_a;
    logic [31:0]         v_b;
    logic [31:0]         v_c;

    ies_seq ies_seq_i (.clk_sys(clk_sys), .rst(rst), .wb_i(wb_i), .wb_o(wb_o), .cmd(cmd),
        .res(res), .mem_o(mem_o), .mem_ack(mem_ack), .mem_rd(mem_rd), .irq_hw(irq_hw),
        .flags_o(flags_o), .req_o(req_o));
    ies_mem_model ies_mem_model_i (.clk_sys(clk_sys), .mem_o(mem_o), .mem_ack(mem_ack),
        .mem_rd(mem_rd));

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask : chk

    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int i;
        @(posedge clk_sys);
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (wb_o.ack) break;
        end
        wb_i.cyc <= 1'b0;
        wb_i.stb <= 1'b0;
        if (i == 50) begin
            err_count++;
            wrap_up();
        end
    endtask : wb

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        rq.push_back(exp);
        wb(1'b0, adr, 32'h0);
    endtask : rd

    // k: bit0 return, bit1 enable, bit2 disable, bit3 sequence expected
    task automatic go(input logic [3:0] k, input logic [63:0] exp);
        int i;
        @(posedge clk_sys);
        cmd.boundary <= 1'b1;
        cmd.return_from_interrupt     <= k[0];
        cmd.ei       <= k[1];
        cmd.di       <= k[2];
        @(posedge clk_sys);
        cmd.boundary <= 1'b0;
        cmd.return_from_interrupt     <= 1'b0;
        cmd.ei       <= 1'b0;
        cmd.di       <= 1'b0;
        if (k[3]) begin
            dq.push_back(exp);
            for (i = 0; i < 300; i++) begin
                @(posedge clk_sys);
                if (res.done) break;
            end
            if (i == 300) begin
                err_count++;
                wrap_up();
            end
        end else begin
            repeat (3) begin
                @(posedge clk_sys);
                if (k == 4'h0) chk("busy", res.busy, 1'b0);
            end
        end
    endtask : go

    task automatic fetch(input logic [31:0] pc);
        @(posedge clk_sys);
        cmd.fetch    <= 1'b1;
        cmd.fetch_pc <= pc;
        @(posedge clk_sys);
        cmd.fetch    <= 1'b0;
    endtask : fetch

    task automatic put32(input logic [31:0] a, input logic [31:0] v);
        for (int b = 0; b < 4; b++) ies_mem_model_i.mem[a + b] = v[31 - 8 * b -: 8];
    endtask : put32

    task automatic stack(input logic [31:0] s, input logic [7:0] f, input logic [31:0] pc);
        chk("flags slot", ies_mem_model_i.mem[s - 32'h1], f);
        for (int b = 0; b < 4; b++) begin
            chk("pc slot", ies_mem_model_i.mem[s - 32'h3 - b], pc[8 * b +: 8]);
        end
    endtask : stack

    always @(posedge clk_sys) begin
        if (wb_o.ack && !wb_i.we) chk("read data", wb_o.dat, rq.pop_front());
        if (res.done) chk("pc and sp", {res.pc, res.sp}, dq.pop_front());
    end

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        rst    = 1'b1;
        wb_i   = '0;
        cmd    = '0;
        irq_hw = 8'h00;
        s_ptr  = 32'h0000_4000 + ($random(seed) & 32'h0000_0FF0);
        r_pc   = $random(seed) & 32'hFFFF_FFFE;
        v_a    = $random(seed);
        v_b    = $random(seed);
        v_c    = $random(seed);
        put32(ies_pkg::IRQ_VEC_BASE + 32'hC, v_a);
        put32(ies_pkg::IRQ_VEC_BASE + 32'h14, v_b);
        put32(ies_pkg::EXC_VECTOR, v_c);
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rd(ies_pkg::OFS_FLAGS, 32'h0);
        rd(ies_pkg::OFS_REQ, 32'h0);
        rd(ies_pkg::OFS_ENABLE, 32'h0);
        rd(ies_pkg::OFS_PC_LIMIT, 32'hFFFF_FFFF);
        rd(ies_pkg::OFS_SYS_EXC, 32'h0);
        rd(8'h18, 32'h0);
        wb(1'b1, ies_pkg::OFS_ENABLE, 32'h28);
        rd(ies_pkg::OFS_ENABLE, 32'h28);
        wb(1'b1, ies_pkg::OFS_REQ_SET, 32'h80);
        rd(ies_pkg::OFS_REQ, 32'h80);
        go(4'h2, '0);
        chk("flags", flags_o, 8'h01);
        go(4'h0, '0);
        wb(1'b1, ies_pkg::OFS_REQ, 32'h80);
        rd(ies_pkg::OFS_REQ_SET, 32'h0);
        cmd.sp     <= s_ptr;
        cmd.ret_pc <= r_pc;
        @(posedge clk_sys);
        irq_hw <= 8'h28;
        @(posedge clk_sys);
        irq_hw <= 8'h00;
        go(4'h8, {v_a, s_ptr - 32'h6});
        stack(s_ptr, 8'h01, r_pc);
        chk("pad slot", ies_mem_model_i.mem[s_ptr - 32'h2], 8'h00);
        chk("flags", flags_o, 8'h02);
        chk("requests", req_o, 8'h20);
        cmd.sp <= s_ptr - 32'h6;
        go(4'h9, {v_b, s_ptr - 32'h6});
        chk("flags", flags_o, 8'h02);
        chk("requests", req_o, 8'h00);
        wb(1'b1, ies_pkg::OFS_FLAGS, 32'h0);
        go(4'h9, {r_pc, s_ptr});
        chk("flags", flags_o, 8'h01);
        go(4'h4, '0);
        chk("flags", flags_o, 8'h00);
        wb(1'b1, ies_pkg::OFS_PC_LIMIT, 32'h0000_1000);
        fetch(32'h0000_1000);
        go(4'h0, '0);
        cmd.sp     <= s_ptr - 32'h100;
        cmd.ret_pc <= r_pc ^ 32'h10;
        fetch(32'h0000_1002);
        go(4'h8, {v_c, s_ptr - 32'h106});
        stack(s_ptr - 32'h100, 8'h00, r_pc ^ 32'h10);
        rd(ies_pkg::OFS_SYS_EXC, 32'h1);
        fetch(32'h0000_2000);
        go(4'h0, '0);
        wb(1'b1, ies_pkg::OFS_SYS_EXC, 32'h0);
        rd(ies_pkg::OFS_SYS_EXC, 32'h1);
        wb(1'b1, ies_pkg::OFS_SYS_EXC, 32'h1);
        rd(ies_pkg::OFS_SYS_EXC, 32'h0);
        go(4'h2, '0);
        cmd.sp        <= s_ptr - 32'h200;
        cmd.exc_raise <= 1'b1;
        @(posedge clk_sys);
        cmd.exc_raise <= 1'b0;
        go(4'h8, {v_c, s_ptr - 32'h206});
        chk("flags", flags_o, 8'h03);
        stack(s_ptr - 32'h200, 8'h01, r_pc ^ 32'h10);
        repeat (3) @(posedge clk_sys);
        wrap_up();
    end
endmodule : tb_ies_seq
